// ### core/ifw_top.sv
// Interrupt flag, enable and wake logic with Wishbone register access
// How it works
// - Comparator change sets flag bit 6
// - Comparator flag only with a wake disable clear
// - Timer overflow sets bit 5; software clears
// - Pin change sets bit 4; software clears
// - Pin flag needs port wake disable clear
// - Bit 0 global enable allows vectoring
// - Enable bit 6 gates comparator interrupt
// - Enable bit 5 gates timer interrupt
// - Enable bit 4 gates pin-change interrupt
// - Enable bit 0 selects wake reset
// - Conversion done sets bit 7; software clears
// - Flags set whatever the enables are
// - Taking interrupt flushes, clears enable, pushes, vectors
`include "ifw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ifw_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [`IFW_ADDR_W-1:0] adr_i,
   input wire logic [0:0] sel_i,
   input wire logic [7:0] dat_i,
   output logic [7:0] dat_o,
   output logic ack_o,
   // Peripheral events
   input wire logic conv_done_i,
   input wire logic cmp1_out_i,
   input wire logic cmp2_out_i,
   input wire logic [7:0] timer_count_i,
   input wire logic port_change_i,
   // Core sequencer
   input wire logic sleeping_i,
   input wire logic core_ready_i,
   input wire logic core_retfie_i,
   output logic irq_o,
   output logic take_o,
   output logic flush_o,
   output logic push_pc_o,
   output logic [10:0] vector_o,
   output logic wake_o,
   output logic wake_reset_o
);
   typedef struct packed {
      ifw_pkg::ifw_byte_t flags;
      ifw_pkg::ifw_byte_t enables;
      logic cmp1_wake_dis;
      logic cmp2_wake_dis;
      logic port_wake_dis;
      ifw_pkg::ifw_state_t state;
      logic [7:0] timer_prev;
      logic timer_primed;
      ifw_pkg::ifw_byte_t rdata;
      logic take;
      logic wake;
      logic wake_rst;
   } ifw_st_t;

   ifw_st_t st_reg;
   ifw_st_t st_next;
   logic wr;
   logic rd;
   logic cmp1_chg;
   logic cmp2_chg;
   logic tmr_ovf;
   logic [7:0] set_vec;
   logic [7:0] pending;
   logic any_pending;

   ifw_wb u_wb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .sel_i(sel_i),
      .ack_o(ack_o),
      .wr_o(wr),
      .rd_o(rd)
   );

   ifw_edge u_cmp1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(cmp1_out_i),
      .change_o(cmp1_chg)
   );

   ifw_edge u_cmp2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(cmp2_out_i),
      .change_o(cmp2_chg)
   );

   // Overflow is the count wrapping from its top value to zero
   assign tmr_ovf = st_reg.timer_primed && (st_reg.timer_prev == `IFW_TIMER_MAX)
      && (timer_count_i == 8'h00);

   always_comb begin
      set_vec = 8'h00;
      set_vec[`IFW_BIT_CONV] = conv_done_i;
      set_vec[`IFW_BIT_CMP] = (cmp1_chg || cmp2_chg)
         && (!st_reg.cmp1_wake_dis || !st_reg.cmp2_wake_dis);
      set_vec[`IFW_BIT_TMR] = tmr_ovf;
      set_vec[`IFW_BIT_PORT] = port_change_i && !st_reg.port_wake_dis;
   end

   // Enables gate each source flag (bits 7 to 4) onto the request
   assign pending = st_reg.flags & st_reg.enables & `IFW_SRC_MASK;
   assign any_pending = |pending;

   always_comb begin
      st_next = st_reg;
      st_next.timer_prev = timer_count_i;
      st_next.timer_primed = 1'b1;
      st_next.take = 1'b0;
      st_next.wake = 1'b0;
      st_next.wake_rst = 1'b0;
      // Register writes land first so hardware sets win below
      if (wr) begin
         case (adr_i)
            `IFW_OFF_FLAGS: begin
               st_next.flags = dat_i & `IFW_IMPL_MASK;
            end
            `IFW_OFF_ENABLES: begin
               st_next.enables = dat_i & `IFW_IMPL_MASK;
            end
            `IFW_OFF_WAKECFG: begin
               st_next.cmp1_wake_dis = dat_i[0];
               st_next.cmp2_wake_dis = dat_i[1];
               st_next.port_wake_dis = dat_i[2];
            end
            default: begin
            end
         endcase
      end
      // Sources set regardless of any enable
      st_next.flags = st_next.flags | set_vec;
      if (core_retfie_i) begin
         st_next.flags[`IFW_BIT_GIE] = 1'b1;
      end
      case (st_reg.state)
         ifw_pkg::IFW_RUN: begin
            if (sleeping_i && any_pending) begin
               st_next.state = ifw_pkg::IFW_WAKE;
               if (st_reg.enables[`IFW_BIT_WUR]) begin
                  st_next.wake_rst = 1'b1;
               end else begin
                  st_next.wake = 1'b1;
               end
            end else if (!sleeping_i && any_pending && st_reg.flags[`IFW_BIT_GIE]
                         && core_ready_i) begin
               st_next.state = ifw_pkg::IFW_VEC;
               st_next.take = 1'b1;
               st_next.flags[`IFW_BIT_GIE] = 1'b0;
            end
         end
         ifw_pkg::IFW_VEC: begin
            st_next.state = ifw_pkg::IFW_RUN;
         end
         ifw_pkg::IFW_WAKE: begin
            if (!sleeping_i) begin
               st_next.state = ifw_pkg::IFW_RUN;
            end
         end
         default: begin
            st_next.state = ifw_pkg::IFW_RUN;
         end
      endcase
      if (rd) begin
         case (adr_i)
            `IFW_OFF_FLAGS: st_next.rdata = st_reg.flags & `IFW_IMPL_MASK;
            `IFW_OFF_ENABLES: st_next.rdata = st_reg.enables & `IFW_IMPL_MASK;
            `IFW_OFF_WAKECFG: st_next.rdata = {5'h00, st_reg.port_wake_dis,
               st_reg.cmp2_wake_dis, st_reg.cmp1_wake_dis};
            `IFW_OFF_STATUS: st_next.rdata = pending | {7'h00, any_pending};
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.flags <= `IFW_FLAGS_RST;
         st_reg.enables <= `IFW_ENABLES_RST;
         st_reg.cmp1_wake_dis <= 1'b1;
         st_reg.cmp2_wake_dis <= 1'b1;
         st_reg.port_wake_dis <= 1'b1;
         st_reg.state <= ifw_pkg::IFW_RUN;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dat_o = st_reg.rdata;
   assign irq_o = any_pending;
   assign take_o = st_reg.take;
   assign flush_o = st_reg.take;
   assign push_pc_o = st_reg.take;
   assign vector_o = `IFW_VECTOR;
   assign wake_o = st_reg.wake;
   assign wake_reset_o = st_reg.wake_rst;
endmodule : ifw_top
`default_nettype wire

// ### core/ifw_cfg.svh
// Offsets, field positions, reset values and counts for the interrupt flag block
`ifndef IFW_CFG_SVH
`define IFW_CFG_SVH
`define IFW_ADDR_W 2
`define IFW_OFF_FLAGS 2'h0
`define IFW_OFF_ENABLES 2'h1
`define IFW_OFF_WAKECFG 2'h2
`define IFW_OFF_STATUS 2'h3
`define IFW_BIT_CONV 7
`define IFW_BIT_CMP 6
`define IFW_BIT_TMR 5
`define IFW_BIT_PORT 4
`define IFW_BIT_GIE 0
`define IFW_BIT_WUR 0
`define IFW_IMPL_MASK 8'hf1
`define IFW_SRC_MASK 8'hf0
`define IFW_FLAGS_RST 8'h00
`define IFW_ENABLES_RST 8'h00
`define IFW_WAKECFG_RST 8'h07
`define IFW_VECTOR 11'h004
`define IFW_TIMER_MAX 8'hff
`endif

// ### core/ifw_pkg.sv
// Types shared by the interrupt flag block
package ifw_pkg;
   typedef enum logic [2:0] {
      IFW_RUN = 3'b001,
      IFW_VEC = 3'b010,
      IFW_WAKE = 3'b100
   } ifw_state_t;
   typedef logic [7:0] ifw_byte_t;
endpackage : ifw_pkg

// ### core/ifw_edge.sv
// Change event detector for one source
`timescale 1ns/1ps
`default_nettype none
module ifw_edge (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Source level and event out
   input wire logic level_i,
   output logic change_o
);
   typedef struct packed {
      logic prev;
      logic primed;
   } ifw_edge_st_t;
   ifw_edge_st_t st_reg;
   ifw_edge_st_t st_next;
   always_comb begin
      st_next = st_reg;
      st_next.prev = level_i;
      st_next.primed = 1'b1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   // No event in the first cycle after reset
   assign change_o = st_reg.primed && (st_reg.prev != level_i);
endmodule : ifw_edge
`default_nettype wire

// ### core/ifw_wb.sv
// Classic Wishbone slave front end with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module ifw_wb (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [0:0] sel_i,
   output logic ack_o,
   // Access strobes
   output logic wr_o,
   output logic rd_o
);
   typedef struct packed {
      logic ack;
   } ifw_wb_st_t;
   ifw_wb_st_t st_reg;
   ifw_wb_st_t st_next;
   logic req;
   assign req = cyc_i && stb_i && !st_reg.ack;
   always_comb begin
      st_next = st_reg;
      st_next.ack = req;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign ack_o = st_reg.ack;
   // Write takes effect at the acking edge
   assign wr_o = st_reg.ack && cyc_i && stb_i && we_i && sel_i[0];
   assign rd_o = req && !we_i;
endmodule : ifw_wb
`default_nettype wire

// ### tb/ifw_checker.sv
// Port assertions for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module ifw_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Core
   input wire logic sleeping_i,
   input wire logic core_ready_i,
   input wire logic core_retfie_i,
   input wire logic irq_o,
   input wire logic take_o,
   input wire logic flush_o,
   input wire logic push_pc_o,
   input wire logic [10:0] vector_o,
   input wire logic wake_o,
   input wire logic wake_reset_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_one_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing");
   ack_drop_a: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   take_cause_a: assert property (take_o |-> $past(irq_o && core_ready_i && !sleeping_i))
      else $error("take without cause");
   take_trio_a: assert property (take_o == flush_o && take_o == push_pc_o)
      else $error("take strobes differ");
   take_vector_a: assert property (take_o |-> vector_o == 11'h004)
      else $error("bad vector");
   take_once_a: assert property (take_o && !core_retfie_i && !cyc_i
      ##1 (!core_retfie_i && !cyc_i) [*4] |-> !take_o)
      else $error("enable not cleared");
   wake_excl_a: assert property (!(wake_o && wake_reset_o))
      else $error("both wake kinds");
   wake_cause_a: assert property (wake_o || wake_reset_o |-> $past(sleeping_i && irq_o))
      else $error("wake without cause");
endmodule : ifw_checker
bind ifw_top ifw_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .sleeping_i(sleeping_i), .core_ready_i(core_ready_i), .irq_o(irq_o),
   .core_retfie_i(core_retfie_i), .take_o(take_o), .flush_o(flush_o), .push_pc_o(push_pc_o),
   .vector_o(vector_o), .wake_o(wake_o), .wake_reset_o(wake_reset_o));
`default_nettype wire

// ### tb/ifw_core_model.sv
// Core sequencer model: readiness, sleep and service return
`timescale 1ns/1ps
`default_nettype none
module ifw_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Commands
   input wire logic slow_i,
   input wire logic sleep_i,
   input wire logic ret_i,
   input wire logic wake_i,
   // Core side
   output logic ready_o,
   output logic sleeping_o,
   output logic retfie_o
);
   logic [1:0] ph;
   always_ff @(posedge clk_i) begin
      ph <= rst_i ? 2'h0 : ph + 2'h1;
      sleeping_o <= !rst_i && (sleep_i || (sleeping_o && !wake_i));
      retfie_o <= !rst_i && ret_i;
   end
   assign ready_o = !slow_i || ph == 2'h3;
endmodule : ifw_core_model
`default_nettype wire

// ### tb/ifw_top_bench.sv
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module ifw_top_bench;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, conv_done_i = 0;
   logic cmp1_out_i = 0, cmp2_out_i = 0, port_change_i = 0, slow = 0, sleep = 0, ret = 0;
   logic [0:0] sel_i = 1'b1;
   logic [1:0] adr_i = 2'h0;
   logic [7:0] dat_i = 8'h00, timer_count_i = 8'h00, dat_o, q;
   logic ack_o, irq_o, take_o, flush_o, push_pc_o, wake_o, wake_reset_o, slp, rdy, rfi;
   logic [10:0] vector_o;
   logic [7:0] cf[7] = '{8'h07, 8'h07, 8'h06, 8'h05, 8'h07, 8'h07, 8'h03};
   logic [7:0] ex[7] = '{8'h80, 8'h00, 8'h40, 8'h40, 8'h20, 8'h00, 8'h10};
   int kd[7] = '{0, 1, 1, 2, 3, 4, 4};
   int err_total = 0, comparisons = 0, takes = 0, wakes = 0, resets = 0, cyc = 0;
   initial forever #20 clk_i = ~clk_i;
   ifw_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .conv_done_i(conv_done_i), .cmp1_out_i(cmp1_out_i), .cmp2_out_i(cmp2_out_i),
      .timer_count_i(timer_count_i), .port_change_i(port_change_i), .sleeping_i(slp),
      .core_ready_i(rdy), .core_retfie_i(rfi), .irq_o(irq_o), .take_o(take_o),
      .flush_o(flush_o), .push_pc_o(push_pc_o), .vector_o(vector_o), .wake_o(wake_o),
      .wake_reset_o(wake_reset_o));
   ifw_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .sleep_i(sleep),
      .ret_i(ret), .wake_i(wake_o | wake_reset_o), .ready_o(rdy), .sleeping_o(slp),
      .retfie_o(rfi));
   task wrap_up;
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   always @(posedge clk_i) begin
      cyc++;
      if (take_o === 1'b1) takes++;
      if (wake_o === 1'b1) wakes++;
      if (wake_reset_o === 1'b1) resets++;
      if (cyc == 3000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic [1:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) begin
         err_total++;
         $display("ERROR %0t: no bus answer", $time);
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      wb(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      chk(q, e);
   endtask : rd
   task automatic ev(input int k);
      case (k)
         0: conv_done_i <= 1'b1;
         1: cmp1_out_i <= ~cmp1_out_i;
         2: cmp2_out_i <= ~cmp2_out_i;
         3: timer_count_i <= 8'hff;
         default: port_change_i <= 1'b1;
      endcase
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      port_change_i <= 1'b0;
      timer_count_i <= 8'h00;
      repeat (3) @(posedge clk_i);
   endtask : ev
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h07);
      wr(2'h0, 8'hff);
      rd(2'h0, 8'hf1);
      sel_i <= 1'b0;
      wr(2'h1, 8'hff);
      sel_i <= 1'b1;
      rd(2'h1, 8'h00);
      $display("reset and reserved bits done");
      for (int i = 0; i < 7; i++) begin
         wr(2'h2, cf[i]);
         wr(2'h0, 8'h00);
         ev(kd[i]);
         rd(2'h0, ex[i]);
      end
      $display("event flags done");
      for (int i = 4; i < 8; i++) begin
         wr(2'h0, 8'h01 << i);
         wr(2'h1, 8'hf0 ^ (8'h01 << i));
         chk({7'h00, irq_o}, 8'h00);
         rd(2'h3, 8'h00);
         wr(2'h1, 8'h01 << i);
         chk({7'h00, irq_o}, 8'h01);
         rd(2'h3, (8'h01 << i) | 8'h01);
      end
      chk(8'(takes), 8'h00);
      $display("enable gating done");
      wr(2'h1, 8'h80);
      slow <= 1'b1;
      wr(2'h0, 8'h81);
      repeat (8) @(posedge clk_i);
      chk(8'(takes), 8'h01);
      rd(2'h0, 8'h80);
      ret <= 1'b1;
      @(posedge clk_i);
      ret <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk(8'(takes), 8'h02);
      $display("vectoring done");
      slow <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         wr(2'h0, 8'h00);
         wr(2'h1, 8'h10 | 8'(i));
         sleep <= 1'b1;
         @(posedge clk_i);
         sleep <= 1'b0;
         wr(2'h0, 8'h10);
         repeat (4) @(posedge clk_i);
         chk(8'(wakes), 8'h01);
         chk(8'(resets), 8'(i));
      end
      $display("sleep wake done");
      wrap_up();
   end
endmodule : ifw_top_bench
`default_nettype wire
